// *** sim/ssrd_chain_model.sv ***
// upstream chain model driving the two safety channels
`timescale 1ns/1ps
`default_nettype none
module ssrd_chain_model (
  input  wire logic       mclk,
  input  wire logic       rstn,
  input  wire logic       chain_closed,
  input  wire logic [7:0] skew,
  output var  logic       safety_input_a,
  output var  logic       safety_input_b
);
  logic [7:0] lag_q;
  // a opens at once, b opens skew cycles later; closing joins both
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      lag_q <= 8'h00;
      safety_input_a <= 1'b0;
      safety_input_b <= 1'b0;
    end else if (chain_closed) begin
      lag_q <= 8'h00;
      safety_input_a <= 1'b1;
      safety_input_b <= 1'b1;
    end else begin
      safety_input_a <= 1'b0;
      if (lag_q >= skew) begin
        safety_input_b <= 1'b0;
      end else begin
        lag_q <= lag_q + 8'h01;
      end
    end
  end
endmodule // ssrd_chain_model
`default_nettype wire

// *** sim/ssrd_top_tb_top.sv ***
// self-checking bench of the release and diagnostic block
`timescale 1ns/1ps
`default_nettype none
module ssrd_top_tb_top;
  import ssrd_pkg::*;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic chain = 1'b1;
  logic fb = 1'b0;
  logic rbtn = 1'b0;
  logic abtn = 1'b0;
  logic act = 1'b1;
  logic lim = 1'b0;
  logic comm = 1'b0;
  logic nv_cell = 1'b0;
  logic [7:0] skew = 8'h00;
  logic [5:0] wsrc = 6'h00;
  logic [5:0] esrc = 6'h00;
  logic in_a, in_b, out_a, out_b, irq, nv_out;
  logic [31:0] rdata;
  ssrd_leds_t leds;
  ssrd_pins_t pins_w;
  ssrd_bus_req_t bus_q = '0;
  int failures = 0;
  int checks = 0;
  int n;
  int nv_hold;
  logic y_prev;

  always #10 mclk = ~mclk;
  assign pins_w = {in_a, in_b, fb, rbtn, abtn, act, lim, comm, nv_cell, wsrc, esrc};
  // the non-volatile cell keeps its value while reset is low, like a lost supply
  // the cell is only written once the block has reloaded it after a power-up
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) nv_hold <= 0;
    else if (nv_hold < 8) nv_hold <= nv_hold + 1;
    else nv_cell <= nv_out;
  end

  ssrd_chain_model ssrd_chain_model_inst (.mclk(mclk), .rstn(rstn), .chain_closed(chain),
    .skew(skew), .safety_input_a(in_a), .safety_input_b(in_b));
  ssrd_top #(.BLINK5_N(4), .BLINK1_N(8), .DISC_N(20), .WARN_N(50)) ssrd_top_inst (
    .mclk(mclk), .rstn(rstn), .pins(pins_w), .bus(bus_q), .rdata(rdata),
    .safety_output_a(out_a), .safety_output_b(out_b), .leds(leds), .irq(irq),
    .nv_disc_out(nv_out));

  // ----------------------------------------
  // bus access and comparison
  // ----------------------------------------
  task automatic close_out;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge mclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk);
    bus_q <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    bus_q <= '0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string w);
    @(posedge mclk);
    bus_q <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    bus_q <= '0;
    #1 chk(w, e, rdata & m);
  endtask
  // bounded wait for both outputs; a hang ends the run
  task automatic wait_out(input logic e, input int lim_c);
    for (int i = 0; i < lim_c; i++) begin
      @(posedge mclk);
      #1 if (out_a === e && out_b === e) return;
    end
    chk("safety outputs", {31'h0, e}, {31'h0, out_a});
    close_out();
  endtask
  task automatic trip;
    skew <= 8'hff;
    chain <= 1'b0;
    cyc(30);
    chain <= 1'b1;
    cyc(6);
  endtask

  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial begin
    cyc(8);
    rstn <= 1'b1;
    cyc(6);
    chk("outputs at power-up", 32'h0, {out_a, out_b});
    rd(ADDR_RESPONSE, 32'hff, 32'h1a, "response waiting");
    n = 0;
    y_prev = leds.yellow;
    for (int i = 0; i < 40; i++) begin
      @(posedge mclk);
      #1 if (leds.yellow !== y_prev) n++;
      y_prev = leds.yellow;
    end
    chk("yellow toggles", 32'h0000_000a, n);
    $display("power_up done");
    wr(ADDR_IRQ_MASK, 32'h0000_000f);
    fb <= 1'b1;
    wait_out(1'b1, 10);
    cyc(2);
    chk("yellow steady", 32'h1, {31'h0, leds.yellow});
    rd(ADDR_RESPONSE, 32'hff, 32'h13, "response released");
    lim <= 1'b1;
    cyc(4);
    rd(ADDR_RESPONSE, 32'h20, 32'h20, "response limit");
    lim <= 1'b0;
    $display("auto release done");
    wsrc <= 6'h08;
    comm <= 1'b1;
    cyc(4);
    rd(ADDR_WARNING, 32'hff, 32'h48, "warning byte");
    rd(ADDR_RESPONSE, 32'hc1, 32'h41, "response warning");
    wait_out(1'b0, 100);
    wsrc <= 6'h00;
    comm <= 1'b0;
    wait_out(1'b1, 20);
    $display("warning done");
    esrc <= 6'h10;
    wait_out(1'b0, 10);
    esrc <= 6'h00;
    cyc(4);
    rd(ADDR_ERROR, 32'hff, 32'h10, "error byte");
    rd(ADDR_RESPONSE, 32'h81, 32'h80, "response error");
    wr(ADDR_REQUEST, 32'h0000_0080);
    wr(ADDR_REQUEST, 32'h0000_0000);
    cyc(4);
    rd(ADDR_ERROR, 32'hff, 32'h00, "error cleared");
    wait_out(1'b1, 20);
    $display("error done");
    wr(ADDR_CONFIG, 32'h0000_0002);
    trip();
    chk("outputs after discrepancy", 32'h0, {out_a, out_b});
    rd(ADDR_ERROR, 32'h40, 32'h40, "discrepancy bit");
    rd(ADDR_IRQ_STAT, 32'h08, 32'h08, "discrepancy irq");
    chk("irq", 32'h1, {31'h0, irq});
    cyc(10);
    chk("outputs blocked", 32'h0, {out_a, out_b});
    rstn <= 1'b0;
    cyc(3);
    rstn <= 1'b1;
    cyc(8);
    rd(ADDR_ERROR, 32'h40, 32'h40, "discrepancy after power loss");
    chk("outputs after power loss", 32'h0, {out_a, out_b});
    abtn <= 1'b1;
    cyc(4);
    abtn <= 1'b0;
    cyc(6);
    rd(ADDR_ERROR, 32'h40, 32'h00, "button acknowledge");
    wait_out(1'b1, 20);
    wr(ADDR_IRQ_MASK, 32'h0000_000f);
    wr(ADDR_CONFIG, 32'h0000_0002);
    trip();
    rd(ADDR_ERROR, 32'h40, 32'h40, "second discrepancy");
    wr(ADDR_REQUEST, 32'h0000_0040);
    cyc(3);
    rd(ADDR_ERROR, 32'h40, 32'h00, "bus acknowledge");
    wait_out(1'b1, 20);
    wr(ADDR_IRQ_STAT, 32'h0000_000f);
    cyc(2);
    rd(ADDR_IRQ_STAT, 32'h0f, 32'h00, "irq cleared");
    chk("irq low", 32'h0, {31'h0, irq});
    $display("discrepancy done");
    wr(ADDR_CONFIG, 32'h0000_0001);
    act <= 1'b0;
    wait_out(1'b0, 10);
    act <= 1'b1;
    cyc(6);
    chk("no release on level", 32'h0, {out_a, out_b});
    rbtn <= 1'b1;
    cyc(4);
    chk("no release on press", 32'h0, {out_a, out_b});
    rbtn <= 1'b0;
    wait_out(1'b1, 10);
    $display("button release done");
    close_out();
  end
endmodule // ssrd_top_tb_top
`default_nettype wire

// *** verilog/ssrd_pkg.sv ***
// package for the safety sensor release and diagnostic block
//
// Functional notes
// RQ1: response bit 4 shows both inputs live
// RQ2: response bit 5 shows actuation in limit zone
// RQ3: diagnostic bits 2,3,5 and error bit 4 positional
// RQ4: warning bit 6 flags gateway communication failure
// RQ5: error bit 6 flags discrepancy time exceeded
// RQ6: power-up: outputs off, yellow blinks 5 Hz
// RQ7: auto variant releases when feedback closes
// RQ8: button variant releases on button falling edge
// RQ9: auto variant needs no edge, level suffices
// RQ10: inputs differing over 500 ms switch outputs off
// RQ11: discrepancy fault blocks release until acknowledged
// RQ12: discrepancy fault survives supply loss
// RQ13: acknowledge by button falling edge or request bit 6
// RQ14: fault clears: cause gone and bit7 fall or guard open
// RQ15: response bit 6 warning, bit 7 error off
// RQ16: warning held 30 minutes switches outputs off
package ssrd_pkg;

  // ------------------------------------------------------------
  // clock and timing
  // ------------------------------------------------------------
  localparam longint CLK_HZ        = 50_000_000;
  localparam longint BLINK5_HZ     = 5;
  localparam longint BLINK1_HZ     = 1;
  localparam longint DISC_MS       = 500;
  localparam longint WARN_MIN      = 30;
  // half periods of the blink rates, longest times round down
  localparam longint BLINK5_CYC    = CLK_HZ / (2 * BLINK5_HZ);
  localparam longint BLINK1_CYC    = CLK_HZ / (2 * BLINK1_HZ);
  // least times round up
  localparam longint DISC_CYC      = (DISC_MS * CLK_HZ + 999) / 1000;
  localparam longint WARN_CYC      = WARN_MIN * 60 * CLK_HZ;
  localparam int     BLINK_CW      = 25;
  localparam int     DISC_CW       = 26;
  localparam int     WARN_CW       = 37;
  localparam int     NV_LOAD_CYC   = 3;

  // ------------------------------------------------------------
  // register map, byte addresses
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_REQUEST  = 8'h00;
  localparam logic [7:0] ADDR_RESPONSE = 8'h04;
  localparam logic [7:0] ADDR_WARNING  = 8'h08;
  localparam logic [7:0] ADDR_ERROR    = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;
  localparam logic [7:0] ADDR_CONFIG   = 8'h18;

  // field positions
  localparam int REQ_ACK_BIT   = 6;
  localparam int REQ_RESET_BIT = 7;
  localparam int CFG_VARIANT   = 0;  // 0 auto_feedback_release, 1 reset_button_release
  localparam int CFG_DISC_EN   = 1;
  localparam int IRQ_OFF       = 0;
  localparam int IRQ_WARN      = 1;
  localparam int IRQ_ERR       = 2;
  localparam int IRQ_DISC      = 3;

  // reset values
  localparam logic [7:0] REQUEST_RST  = 8'h00;
  localparam logic [1:0] CONFIG_RST   = 2'h0;
  localparam logic [3:0] IRQ_MASK_RST = 4'h0;

  // fault sources, one bit per diagnostic cause
  typedef struct packed {
    logic internal;      // diag bit 5
    logic actuator_bad;  // error bit 4
    logic overtemp;      // diag bit 3
    logic cross_wire;    // diag bit 2
    logic out_b;         // diag bit 1
    logic out_a;         // diag bit 0
  } ssrd_faults_t;

  // everything arriving on device pins
  typedef struct packed {
    logic         safety_input_a;
    logic         safety_input_b;
    logic         feedback_closed;
    logic         reset_button;
    logic         ack_button;
    logic         actuator_detected;
    logic         actuator_in_limit;
    logic         comm_fail;
    logic         nv_disc_in;
    ssrd_faults_t warn_src;
    ssrd_faults_t err_src;
  } ssrd_pins_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } ssrd_bus_req_t;

  typedef struct packed {
    logic green;
    logic red;
    logic yellow;
  } ssrd_leds_t;

  typedef enum logic [1:0] {
    ST_WAIT = 2'b00,
    ST_ON   = 2'b01,
    ST_ERR  = 2'b10
  } ssrd_state_t;

endpackage

// *** verilog/ssrd_top.sv ***
// release, discrepancy and diagnostic logic of a chained safety sensor
//
// Design decisions made here: the register addresses and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module ssrd_top #(
  parameter longint BLINK5_N = ssrd_pkg::BLINK5_CYC,
  parameter longint BLINK1_N = ssrd_pkg::BLINK1_CYC,
  parameter longint DISC_N   = ssrd_pkg::DISC_CYC,
  parameter longint WARN_N   = ssrd_pkg::WARN_CYC
) (
  input  wire logic                   mclk,
  input  wire logic                   rstn,
  input  wire ssrd_pkg::ssrd_pins_t   pins,
  input  wire ssrd_pkg::ssrd_bus_req_t bus,
  output var  logic [31:0]            rdata,
  output var  logic                   safety_output_a,
  output var  logic                   safety_output_b,
  output var  ssrd_pkg::ssrd_leds_t   leds,
  output var  logic                   irq,
  output var  logic                   nv_disc_out
);
  import ssrd_pkg::*;

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  ssrd_pins_t s1_q, s_q, p_q;

  // two stages, then one more copy for edge detection
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s1_q <= '0;
      s_q  <= '0;
      p_q  <= '0;
    end else begin
      s1_q <= pins;
      s_q  <= s1_q;
      p_q  <= s_q;
    end
  end

  wire logic both_live = s_q.safety_input_a & s_q.safety_input_b;
  wire logic rb_fall   = p_q.reset_button & ~s_q.reset_button;
  wire logic ack_fall  = p_q.ack_button & ~s_q.ack_button;
  wire logic guard_opn = ~s_q.actuator_detected;

  // ------------------------------------------------------------
  // register bus decode
  // ------------------------------------------------------------
  wire logic wr_req  = bus.wr & (bus.addr == ADDR_REQUEST);
  wire logic wr_stat = bus.wr & (bus.addr == ADDR_IRQ_STAT);
  wire logic wr_mask = bus.wr & (bus.addr == ADDR_IRQ_MASK);
  wire logic wr_cfg  = bus.wr & (bus.addr == ADDR_CONFIG);

  logic [7:0] req_q;
  logic [1:0] cfg_q;
  logic [3:0] mask_q;

  // request bit 7 falling and request bit 6 acknowledge come from writes
  wire logic req7_fall = wr_req & req_q[REQ_RESET_BIT] & ~bus.wdata[REQ_RESET_BIT];
  wire logic bus_ack   = wr_req & bus.wdata[REQ_ACK_BIT];
  wire logic rb_mode   = cfg_q[CFG_VARIANT];
  wire logic disc_en   = cfg_q[CFG_DISC_EN];

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      req_q  <= REQUEST_RST;
      cfg_q  <= CONFIG_RST;
      mask_q <= IRQ_MASK_RST;
    end else begin
      if (wr_req)  req_q  <= bus.wdata[7:0];
      if (wr_cfg)  cfg_q  <= bus.wdata[1:0];
      if (wr_mask) mask_q <= bus.wdata[3:0];
    end
  end

  // ------------------------------------------------------------
  // latched errors
  // ------------------------------------------------------------
  logic [5:0] err_q;
  // a bit leaves only when its cause is gone; a live cause re-sets it
  wire logic       err_clr = req7_fall | guard_opn;                      // RQ14
  wire logic [5:0] err_d   = s_q.err_src | (err_clr ? 6'h00 : err_q);   // RQ14
  wire logic       err_any = |err_q;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) err_q <= 6'h00;
    else       err_q <= err_d;
  end

  // ------------------------------------------------------------
  // discrepancy monitor
  // ------------------------------------------------------------
  logic [DISC_CW-1:0] dcnt_q;
  logic               disc_q;
  logic [1:0]         ld_q;
  // counts while only one input has shut down; a matched drop resets it
  wire logic disc_run = disc_en & (s_q.safety_input_a ^ s_q.safety_input_b);   // RQ10
  wire logic disc_hit = disc_run & (dcnt_q == DISC_CW'(DISC_N));               // RQ10
  wire logic disc_ack = ack_fall | bus_ack;                                    // RQ13
  wire logic nv_load  = (ld_q == 2'(NV_LOAD_CYC - 1));
  // the stored fault is only read once the synchroniser has settled
  wire logic disc_d   = disc_hit | (nv_load & s_q.nv_disc_in) | (disc_q & ~disc_ack); // RQ12

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      dcnt_q <= '0;
      disc_q <= 1'b0;
      ld_q   <= 2'h0;
    end else begin
      dcnt_q <= (disc_run & ~disc_hit) ? dcnt_q + 1'b1 : '0;
      disc_q <= disc_d;
      if (!nv_load && ld_q != 2'(NV_LOAD_CYC)) ld_q <= ld_q + 2'h1;
      else if (nv_load)                       ld_q <= 2'(NV_LOAD_CYC);
    end
  end

  // external non-volatile cell follows the latch continuously
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) nv_disc_out <= 1'b0;
    else       nv_disc_out <= disc_q;                                  // RQ12
  end

  // ------------------------------------------------------------
  // warning and long-warning trip
  // ------------------------------------------------------------
  wire logic [7:0] warn_byte = {1'b0, s_q.comm_fail, s_q.warn_src.internal, 1'b0,  // RQ4 RQ3
                                s_q.warn_src.overtemp, s_q.warn_src.cross_wire,
                                s_q.warn_src.out_b, s_q.warn_src.out_a};
  wire logic [7:0] err_byte  = {1'b0, disc_q, err_q[5], err_q[4],                  // RQ5 RQ3
                                err_q[3], err_q[2], err_q[1], err_q[0]};
  wire logic warn_any = |warn_byte;

  logic [WARN_CW-1:0] wcnt_q;
  logic               trip_q;
  wire logic trip_hit = warn_any & ~trip_q & (wcnt_q == WARN_CW'(WARN_N - 1));    // RQ16

  // the trip only lifts once the warning itself has gone
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wcnt_q <= '0;
      trip_q <= 1'b0;
    end else begin
      wcnt_q <= (warn_any & ~trip_q & ~trip_hit) ? wcnt_q + 1'b1 : '0;
      trip_q <= warn_any & (trip_q | trip_hit);                                    // RQ16
    end
  end

  // ------------------------------------------------------------
  // release state machine
  // ------------------------------------------------------------
  ssrd_state_t state_q, state_d;
  wire logic run_ok  = s_q.actuator_detected & both_live & ~err_any & ~disc_q & ~trip_q; // RQ11
  // auto variant acts on the closed level, the button variant on its edge only
  wire logic rel_ok  = rb_mode ? rb_fall : s_q.feedback_closed;                // RQ7 RQ8 RQ9

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_WAIT: begin
        if (run_ok && rel_ok) state_d = ST_ON;                                 // RQ6 RQ7 RQ8
      end
      ST_ON: begin
        if (err_any || disc_q || trip_q) state_d = ST_ERR;                     // RQ10 RQ16
        else if (!run_ok)                state_d = ST_WAIT;
      end
      ST_ERR: begin
        if (!err_any && !disc_q && !trip_q) state_d = ST_WAIT;                 // RQ11
      end
      default: state_d = ST_WAIT;
    endcase
  end

  logic on_q;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_q <= ST_WAIT;
      on_q    <= 1'b0;
    end else begin
      state_q <= state_d;
      on_q    <= (state_d == ST_ON);
    end
  end
  assign safety_output_a = on_q;
  assign safety_output_b = on_q;

  // ------------------------------------------------------------
  // blink generators and indicators
  // ------------------------------------------------------------
  logic [BLINK_CW-1:0] b5_q, b1_q;
  logic                bl5_q, bl1_q;
  wire logic b5_end = (b5_q == BLINK_CW'(BLINK5_N - 1));
  wire logic b1_end = (b1_q == BLINK_CW'(BLINK1_N - 1));

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      b5_q  <= '0;
      b1_q  <= '0;
      bl5_q <= 1'b0;
      bl1_q <= 1'b0;
    end else begin
      b5_q  <= b5_end ? '0 : b5_q + 1'b1;
      b1_q  <= b1_end ? '0 : b1_q + 1'b1;
      bl5_q <= bl5_q ^ b5_end;
      bl1_q <= bl1_q ^ b1_end;
    end
  end

  // yellow: 5 Hz waiting for release, 1 Hz in the limit zone, steady when on
  wire logic yel_d = (state_q == ST_WAIT) ? (s_q.actuator_detected & bl5_q) :  // RQ6
                     (state_q == ST_ON)   ? (s_q.actuator_in_limit ? bl1_q : 1'b1) : 1'b0;  // RQ7
  wire logic red_d = trip_q ? bl1_q : (err_any | disc_q | warn_any);           // RQ16

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) leds <= '0;
    else       leds <= '{green: ~s_q.actuator_detected | (state_q == ST_WAIT), red: red_d, yellow: yel_d};
  end

  // ------------------------------------------------------------
  // response byte, interrupts, read data
  // ------------------------------------------------------------
  wire logic fb_wait  = rb_mode ? (state_q != ST_ON) : ~s_q.feedback_closed;
  wire logic [7:0] resp_byte = {(state_q == ST_ERR), warn_any,                // RQ15
                                s_q.actuator_in_limit & s_q.actuator_detected, // RQ2
                                both_live, fb_wait, 1'b0,                      // RQ1
                                s_q.actuator_detected, on_q};

  logic       warn_p_q, err_p_q;
  logic [3:0] stat_q;
  wire logic [3:0] ev = {disc_hit, err_any & ~err_p_q, warn_any & ~warn_p_q, on_q & (state_d != ST_ON)};
  // a new event in the clearing cycle survives the clear
  wire logic [3:0] stat_d = ev | (stat_q & ~(wr_stat ? bus.wdata[3:0] : 4'h0));

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      stat_q   <= 4'h0;
      warn_p_q <= 1'b0;
      err_p_q  <= 1'b0;
      irq      <= 1'b0;
    end else begin
      stat_q   <= stat_d;
      warn_p_q <= warn_any;
      err_p_q  <= err_any;
      irq      <= |(stat_d & mask_q);
    end
  end

  wire logic [7:0] rd_mux = (bus.addr == ADDR_REQUEST)  ? req_q :
                            (bus.addr == ADDR_RESPONSE) ? resp_byte :
                            (bus.addr == ADDR_WARNING)  ? warn_byte :
                            (bus.addr == ADDR_ERROR)    ? err_byte :
                            (bus.addr == ADDR_IRQ_STAT) ? {4'h0, stat_q} :
                            (bus.addr == ADDR_IRQ_MASK) ? {4'h0, mask_q} :
                            (bus.addr == ADDR_CONFIG)   ? {6'h00, cfg_q} : 8'h00;

  // read data stands only in the cycle after the strobe
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) rdata <= 32'h0000_0000;
    else       rdata <= bus.rd ? {24'h00_0000, rd_mux} : 32'h0000_0000;
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  sequence rd_of(logic [7:0] a);
    bus.rd && bus.addr == a;
  endsequence

  AST_RESP_INPUTS: assert property (rd_of(ADDR_RESPONSE) |=> rdata[4] == $past(both_live)) // RQ1
    else $error("response bit 4 does not follow both inputs");
  AST_RESP_LIMIT: assert property (rd_of(ADDR_RESPONSE) |=> rdata[5] == $past(resp_byte[5])) // RQ2
    else $error("response bit 5 wrong");
  AST_ERR_POS: assert property (rd_of(ADDR_ERROR) |=> rdata[4] == $past(err_q[4]) && rdata[5] == $past(err_q[5])) // RQ3
    else $error("error byte positions wrong");
  AST_WARN_COMM: assert property (rd_of(ADDR_WARNING) && s_q.comm_fail |=> rdata[6]) // RQ4
    else $error("communication failure not flagged");
  AST_ERR_DISC: assert property (rd_of(ADDR_ERROR) |=> rdata[6] == $past(disc_q)) // RQ5
    else $error("discrepancy bit not flagged");
  AST_WAIT_OFF: assert property (state_q != ST_ON |=> !safety_output_a || $past(state_d) == ST_ON) // RQ6
    else $error("outputs on outside release");
  AST_AUTO_REL: assert property (state_q == ST_WAIT && !rb_mode && run_ok && s_q.feedback_closed
                                 |=> state_q == ST_ON ##0 safety_output_a && safety_output_b) // RQ7
    else $error("auto release missed");
  AST_BTN_EDGE: assert property ($rose(state_q == ST_ON) && $past(rb_mode) |-> $past(rb_fall)) // RQ8
    else $error("button release without falling edge");
  sequence disc_trip;
    disc_hit ##1 disc_q;
  endsequence
  AST_DISC_OFF: assert property (disc_trip |-> ##[1:2] !safety_output_a) // RQ10
    else $error("discrepancy did not switch outputs off");
  AST_DISC_BLOCK: assert property (disc_q && !disc_ack |=> state_q != ST_ON) // RQ11
    else $error("release while discrepancy latched");
  AST_TRIP_OFF: assert property (trip_q |-> ##[1:2] !safety_output_b) // RQ16
    else $error("long warning did not switch off");
  AST_RESP_ERR: assert property (rd_of(ADDR_RESPONSE) |=> rdata[7] == $past(state_q == ST_ERR)) // RQ15
    else $error("response bit 7 wrong");
  AST_RESP_WARN: assert property (rd_of(ADDR_RESPONSE) |=> rdata[6] == $past(warn_any)) // RQ15
    else $error("response bit 6 wrong");

  // the button variant must never release on the feedback level alone
  AST_BTN_LEVEL: assert property (state_q == ST_WAIT && rb_mode && !rb_fall |=> state_q != ST_ON) // RQ8
    else $error("button variant released without an edge");

  // an acknowledge with no new trip and no stored fault loading empties the latch
  sequence ack_seen;
    disc_q && disc_ack && !disc_hit && !nv_load;
  endsequence
  AST_ACK_CLEAR: assert property (ack_seen |=> !disc_q) // RQ13
    else $error("acknowledge did not clear discrepancy");

  // without an acknowledge the latch must hold, otherwise release could slip through
  AST_DISC_HOLD: assert property (disc_q && !disc_ack |=> disc_q) // RQ11
    else $error("discrepancy latch lost without acknowledge");

  // the copy for the non-volatile cell trails the latch by one cycle
  AST_NV_COPY: assert property (1'b1 |=> nv_disc_out == $past(disc_q)) // RQ12
    else $error("non-volatile copy does not follow latch");

  // a clear keeps only the causes still present
  AST_ERR_RESET: assert property (err_clr |=> err_q == $past(s_q.err_src)) // RQ14
    else $error("error latch not reduced to live causes");

  // with no clear a latched error bit never falls
  AST_ERR_HOLD: assert property (!err_clr |=> (err_q & $past(err_q)) == $past(err_q)) // RQ14
    else $error("error bit dropped without clear");

endmodule // ssrd_top
`default_nettype wire
